// ==== rtl/pri_pkg.sv ====
// Package of register map, field positions, reset values and carriers for the interrupt block.
package pri_pkg;
   // Register byte offsets on the APB.
   localparam logic [7:0] OFS_MAIN = 8'h00;
   localparam logic [7:0] OFS_EDGE = 8'h04;
   localparam logic [7:0] OFS_EXT  = 8'h08;
   localparam logic [7:0] OFS_RST  = 8'h0c;
   localparam logic [7:0] OFS_STAT = 8'h10;
   // Main control fields.
   localparam int MC_GH  = 7;
   localparam int MC_GL  = 6;
   localparam int MC_T0E = 5;
   localparam int MC_AE  = 4;
   localparam int MC_PCE = 3;
   localparam int MC_T0F = 2;
   localparam int MC_AF  = 1;
   localparam int MC_PCF = 0;
   // Edge and priority control fields.
   localparam int EP_PUD = 7;
   localparam int EP_AED = 6;
   localparam int EP_BED = 5;
   localparam int EP_CED = 4;
   localparam int EP_T0P = 2;
   localparam int EP_PCP = 0;
   // External lines control fields.
   localparam int EX_CP = 7;
   localparam int EX_BP = 6;
   localparam int EX_CE = 4;
   localparam int EX_BE = 3;
   localparam int EX_CF = 1;
   localparam int EX_BF = 0;
   // Reset control field holding the priority mode enable.
   localparam int RC_PM = 7;
   // Reset values and masks of implemented bits.
   localparam logic [7:0] RST_MAIN  = 8'h00;
   localparam logic [7:0] RST_EDGE  = 8'hf5;
   localparam logic [7:0] RST_EXT   = 8'hc0;
   localparam logic [7:0] MASK_EDGE = 8'hf5;
   localparam logic [7:0] MASK_EXT  = 8'hdb;
   // Entry vectors.
   localparam logic [20:0] VEC_HIGH = 21'h000008;
   localparam logic [20:0] VEC_LOW  = 21'h000018;
   // Timing counts.
   localparam int CLKS_PER_INSTR = 4;
   localparam int LAT_STAGES     = 3;
   // Interrupt entry request to the core.
   typedef struct packed {
      logic        take;
      logic        push;
      logic [20:0] vec;
   } pri_entry_t;
endpackage

// ==== rtl/pri_sync.sv ====
// Two-flop pin synchroniser with rising and falling edge detection.
`timescale 1ns/1ps
module pri_sync #(
   parameter int W = 3
) (
   // Clock and reset.
   input  wire logic         i_ref_clk,
   input  wire logic         i_sys_rst,
   // Pins and synchronised results.
   input  wire logic [W-1:0] i_pin,
   output logic      [W-1:0] o_lvl,
   output logic      [W-1:0] o_rise,
   output logic      [W-1:0] o_fall
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
      logic [W-1:0] prev;
      logic         primed;
   } pri_sync_t;

   pri_sync_t r;
   pri_sync_t n;

   // The first stage feeds only the second; edges come from the second stage.
   always_comb begin
      n        = r;
      n.s1     = i_pin;
      n.s2     = r.s1;
      n.prev   = r.s2;
      n.primed = 1'b1;
   end

   // State register.
   always_ff @(posedge i_ref_clk) begin
      if (i_sys_rst) begin
         r <= '0;
      end else begin
         r <= n;
      end
   end

   // Edges are suppressed only in the first clock after reset; the history stage holds its reset value for two clocks more.
   assign o_lvl  = r.s2;
   assign o_rise = r.s2 & ~r.prev & {W{r.primed}};
   assign o_fall = ~r.s2 & r.prev & {W{r.primed}};
endmodule

// ==== rtl/pri_irq_ctrl.sv ====
// Two-level priority interrupt controller with APB register access.
//
// Functional notes
// - High entry 000008h, low entry 000018h.
// - High preempts low; low waits during high.
// - External line a is always high priority.
// - Priority mode: bit 7 high, bit 6 low.
// - Flag, enable, global enable vector; priority picks.
// - Compatibility mode: one vector, bit 6 peripheral.
// - Entry clears the admitting global enable.
// - Entry pushes return address, loads vector.
// - Return instruction sets the matching global enable.
// - Pin events enter in three to four cycles.
// - Flags set regardless of any enable.
// - Clearing high enable blocks every interrupt.
// - Bit 6 gates low or peripheral sources.
// - Timer and line flags stay until cleared.
// - Port flag set while upper pins mismatch.
// - Edge select bits: 1 rising, 0 falling.
// - Pull-up disable bit overrides port latches.
// - Timer and port priority bits reset high.
// - Line b and c fields in third register.
// - Unimplemented bits ignore writes, read zero.
//
// The APB register port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
module pri_irq_ctrl #(
   parameter int CLKS_PER_INSTR = pri_pkg::CLKS_PER_INSTR
) (
   // Clock and reset.
   input  wire logic               i_ref_clk,
   input  wire logic               i_sys_rst,
   // APB slave.
   input  wire logic               i_psel,
   input  wire logic               i_penable,
   input  wire logic               i_pwrite,
   input  wire logic [7:0]         i_paddr,
   input  wire logic [31:0]        i_pwdata,
   output logic      [31:0]        o_prdata,
   output logic                    o_pready,
   output logic                    o_pslverr,
   // Interrupt sources.
   input  wire logic               i_tmr0_ovf,
   input  wire logic [2:0]         i_ext_line,
   input  wire logic [3:0]         i_upper_port_pins,
   input  wire logic               i_periph_hi_pend,
   input  wire logic               i_periph_lo_pend,
   // Core handshake.
   input  wire logic               i_port_read,
   input  wire logic               i_return_from_irq_instruction,
   output pri_pkg::pri_entry_t     o_entry,
   output logic                    o_port_pullup_disable
);
   ////////////////////////////////////////////////////////////////////////////////
   typedef struct packed {
      logic [7:0]          mc;
      logic [7:0]          ep;
      logic [7:0]          ex;
      logic                pm;
      logic [3:0]          port_lat;
      logic [7:0]          div;
      logic [2:0]          pipe;
      logic                in_hi;
      logic                in_lo;
      logic                pready;
      logic                pslverr;
      logic [31:0]         prdata;
      pri_pkg::pri_entry_t ent;
      logic                pud;
   } pri_state_t;

   pri_state_t r;
   pri_state_t n;

   logic [2:0] ext_lvl;
   logic [2:0] ext_rise;
   logic [2:0] ext_fall;
   logic [3:0] port_lvl;
   logic [2:0] ext_ev;
   logic [4:0] flg;
   logic [4:0] ena;
   logic [4:0] pri;
   logic [4:0] act;
   logic       req_h;
   logic       req_l;
   logic       ok_h;
   logic       ok_l;
   logic       instr_en;
   logic       take;
   logic       take_hi;
   logic       mismatch;
   logic       acc;
   logic       wr_fire;
   logic       hit;
   logic [7:0] rd_byte;
   logic [7:0] wb;

   ////////////////////////////////////////////////////////////////////////////////
   // Pin synchronisers for the external lines and the watched port.
   pri_sync #(.W(3)) u_ext_sync (
      .i_ref_clk (i_ref_clk),
      .i_sys_rst (i_sys_rst),
      .i_pin     (i_ext_line),
      .o_lvl     (ext_lvl),
      .o_rise    (ext_rise),
      .o_fall    (ext_fall)
   );

   pri_sync #(.W(4)) u_port_sync (
      .i_ref_clk (i_ref_clk),
      .i_sys_rst (i_sys_rst),
      .i_pin     (i_upper_port_pins),
      .o_lvl     (port_lvl),
      .o_rise    (),
      .o_fall    ()
   );

   ////////////////////////////////////////////////////////////////////////////////
   // Source decode and eligibility, taken from registered state and the unregistered peripheral pending inputs.
   always_comb begin
      ext_ev[0] = r.ep[pri_pkg::EP_AED] ? ext_rise[0] : ext_fall[0];
      ext_ev[1] = r.ep[pri_pkg::EP_BED] ? ext_rise[1] : ext_fall[1];
      ext_ev[2] = r.ep[pri_pkg::EP_CED] ? ext_rise[2] : ext_fall[2];
      mismatch  = port_lvl != r.port_lat;
      // Order: port, line c, line b, line a, timer.
      flg = {r.mc[pri_pkg::MC_PCF], r.ex[pri_pkg::EX_CF], r.ex[pri_pkg::EX_BF],
             r.mc[pri_pkg::MC_AF], r.mc[pri_pkg::MC_T0F]};
      ena = {r.mc[pri_pkg::MC_PCE], r.ex[pri_pkg::EX_CE], r.ex[pri_pkg::EX_BE],
             r.mc[pri_pkg::MC_AE], r.mc[pri_pkg::MC_T0E]};
      pri = {r.ep[pri_pkg::EP_PCP], r.ex[pri_pkg::EX_CP], r.ex[pri_pkg::EX_BP],
             1'b1, r.ep[pri_pkg::EP_T0P]};
      act = flg & ena;
      if (r.pm) begin
         // High enable gates high sources; low needs both enables.
         req_h = r.mc[pri_pkg::MC_GH] & ((|(act & pri)) | i_periph_hi_pend);
         req_l = r.mc[pri_pkg::MC_GH] & r.mc[pri_pkg::MC_GL] &
                 ((|(act & ~pri)) | i_periph_lo_pend);
      end else begin
         // One global enable, bit 6 gates peripherals, priorities ignored.
         req_h = r.mc[pri_pkg::MC_GH] & ((|act) | (r.mc[pri_pkg::MC_GL] &
                 (i_periph_hi_pend | i_periph_lo_pend)));
         req_l = 1'b0;
      end
      ok_h     = req_h & ~r.in_hi;
      ok_l     = req_l & ~r.in_hi & ~r.in_lo;
      instr_en = r.div == 8'(CLKS_PER_INSTR - 1);
      // Entry on the third eligible boundary bounds pin latency to four instruction cycles.
      take     = instr_en & r.pipe[pri_pkg::LAT_STAGES-2] & (ok_h | ok_l);
      take_hi  = ok_h;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // APB decode and read multiplexer.
   always_comb begin
      acc     = i_psel & i_penable;
      wr_fire = acc & r.pready & i_pwrite;
      wb      = i_pwdata[7:0];
      hit     = 1'b1;
      rd_byte = 8'h00;
      case (i_paddr)
         pri_pkg::OFS_MAIN: rd_byte = r.mc;
         pri_pkg::OFS_EDGE: rd_byte = r.ep & pri_pkg::MASK_EDGE;
         pri_pkg::OFS_EXT:  rd_byte = r.ex & pri_pkg::MASK_EXT;
         pri_pkg::OFS_RST:  rd_byte = {r.pm, 7'h00};
         pri_pkg::OFS_STAT: rd_byte = {6'h00, r.in_hi, r.in_lo};
         default:           hit = 1'b0;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Next-state logic: bus writes first, then hardware sets, entry and return.
   always_comb begin
      n = r;
      // Instruction cycle enable from the clock divider.
      n.div = instr_en ? 8'h00 : r.div + 8'h01;
      // One wait state so that read data come from a register.
      n.pready  = acc & ~r.pready;
      n.pslverr = acc & ~r.pready & ~hit;
      n.prdata  = (acc & ~r.pready) ? {24'h000000, rd_byte} : 32'h00000000;
      if (wr_fire) begin
         case (i_paddr)
            pri_pkg::OFS_MAIN: n.mc = wb;
            pri_pkg::OFS_EDGE: n.ep = wb & pri_pkg::MASK_EDGE;
            pri_pkg::OFS_EXT:  n.ex = wb & pri_pkg::MASK_EXT;
            pri_pkg::OFS_RST:  n.pm = wb[pri_pkg::RC_PM];
            default:           n.pm = r.pm;
         endcase
      end
      // Hardware sets win over a clearing write in the same cycle.
      if (i_tmr0_ovf) begin
         n.mc[pri_pkg::MC_T0F] = 1'b1;
      end
      if (ext_ev[0]) begin
         n.mc[pri_pkg::MC_AF] = 1'b1;
      end
      if (ext_ev[1]) begin
         n.ex[pri_pkg::EX_BF] = 1'b1;
      end
      if (ext_ev[2]) begin
         n.ex[pri_pkg::EX_CF] = 1'b1;
      end
      if (mismatch) begin
         n.mc[pri_pkg::MC_PCF] = 1'b1;
      end
      // A port read captures the pins and so ends the mismatch.
      if (i_port_read) begin
         n.port_lat = port_lvl;
      end
      // Requests must stay eligible for several instruction cycles before entry.
      if (instr_en) begin
         n.pipe = (ok_h | ok_l) ? {r.pipe[1:0], 1'b1} : 3'b000;
      end
      n.ent.take = 1'b0;
      n.ent.push = 1'b0;
      if (take) begin
         n.pipe     = 3'b000;
         n.ent.take = 1'b1;
         n.ent.push = 1'b1;
         n.ent.vec  = take_hi ? pri_pkg::VEC_HIGH : pri_pkg::VEC_LOW;
         if (take_hi) begin
            n.mc[pri_pkg::MC_GH] = 1'b0;
            n.in_hi = 1'b1;
         end else begin
            n.mc[pri_pkg::MC_GL] = 1'b0;
            n.in_lo = 1'b1;
         end
      end else if (i_return_from_irq_instruction) begin
         // Return re-opens the level that was being serviced.
         if (r.pm && !r.in_hi && r.in_lo) begin
            n.mc[pri_pkg::MC_GL] = 1'b1;
            n.in_lo = 1'b0;
         end else begin
            n.mc[pri_pkg::MC_GH] = 1'b1;
            n.in_hi = 1'b0;
            n.in_lo = r.pm & r.in_lo;
         end
      end
      n.pud = r.ep[pri_pkg::EP_PUD];
   end

   ////////////////////////////////////////////////////////////////////////////////
   // State register.
   always_ff @(posedge i_ref_clk) begin
      if (i_sys_rst) begin
         r    <= '0;
         r.mc <= pri_pkg::RST_MAIN;
         r.ep <= pri_pkg::RST_EDGE;
         r.ex <= pri_pkg::RST_EXT;
      end else begin
         r <= n;
      end
   end

   // Outputs come straight from the state register.
   assign o_prdata              = r.prdata;
   assign o_pready              = r.pready;
   assign o_pslverr             = r.pslverr;
   assign o_entry               = r.ent;
   assign o_port_pullup_disable = r.pud;

   ////////////////////////////////////////////////////////////////////////////////
   // Checks on the entry, enable, flag and reserved bit behaviour.
   property p_vec_legal;
      @(posedge i_ref_clk) disable iff (i_sys_rst)
      r.ent.take |-> (r.ent.vec == pri_pkg::VEC_HIGH || r.ent.vec == pri_pkg::VEC_LOW);
   endproperty
   a_vec_legal: assert property (p_vec_legal) else $error("Illegal entry vector.");

   property p_compat_high;
      @(posedge i_ref_clk) disable iff (i_sys_rst)
      (take && !r.pm) |=> (r.ent.vec == pri_pkg::VEC_HIGH);
   endproperty
   a_compat_high: assert property (p_compat_high) else $error("Low vector in compat.");

   property p_clear_gh;
      @(posedge i_ref_clk) disable iff (i_sys_rst)
      (take && take_hi) |=> (!r.mc[pri_pkg::MC_GH] && r.in_hi);
   endproperty
   a_clear_gh: assert property (p_clear_gh) else $error("High enable not cleared.");

   property p_no_low_in_high;
      @(posedge i_ref_clk) disable iff (i_sys_rst)
      r.in_hi |-> !(take && !take_hi);
   endproperty
   a_no_low_in_high: assert property (p_no_low_in_high) else $error("Low taken in high.");

   property p_high_first;
      @(posedge i_ref_clk) disable iff (i_sys_rst)
      (take && ok_h && ok_l) |=> (r.ent.vec == pri_pkg::VEC_HIGH);
   endproperty
   a_high_first: assert property (p_high_first) else $error("Low beat high.");

   property p_tmr_flag;
      @(posedge i_ref_clk) disable iff (i_sys_rst)
      (i_tmr0_ovf || (r.mc[pri_pkg::MC_T0F] && !(wr_fire && i_paddr == pri_pkg::OFS_MAIN)))
         |=> r.mc[pri_pkg::MC_T0F];
   endproperty
   a_tmr_flag: assert property (p_tmr_flag) else $error("Timer flag lost.");

   property p_port_flag;
      @(posedge i_ref_clk) disable iff (i_sys_rst)
      mismatch |=> r.mc[pri_pkg::MC_PCF];
   endproperty
   a_port_flag: assert property (p_port_flag) else $error("Port flag not set.");

   property p_return_from_irq_instruction;
      @(posedge i_ref_clk) disable iff (i_sys_rst)
      (i_return_from_irq_instruction && !take && !r.pm) |=> (r.mc[pri_pkg::MC_GH] && !r.in_hi);
   endproperty
   a_return_from_irq_instruction: assert property (p_return_from_irq_instruction) else $error("Return did not re-enable.");

   property p_latency;
      @(posedge i_ref_clk) disable iff (i_sys_rst)
      take |-> ($past(ok_h | ok_l, CLKS_PER_INSTR) && r.pipe[1]);
   endproperty
   a_latency: assert property (p_latency) else $error("Entry came too early.");

   property p_resv_zero;
      @(posedge i_ref_clk) disable iff (i_sys_rst)
      r.pready |-> (r.ex[5] == 1'b0 && r.ex[2] == 1'b0 && r.ep[3] == 1'b0);
   endproperty
   a_resv_zero: assert property (p_resv_zero) else $error("Reserved bit set.");

   property p_clear_gl;
      @(posedge i_ref_clk) disable iff (i_sys_rst)
      (take && !take_hi) |=> (!r.mc[pri_pkg::MC_GL] && r.in_lo);
   endproperty
   a_clear_gl: assert property (p_clear_gl) else $error("Low enable not cleared.");

   property p_ret_low;
      @(posedge i_ref_clk) disable iff (i_sys_rst)
      (i_return_from_irq_instruction && !take && r.pm && !r.in_hi && r.in_lo)
         |=> (r.mc[pri_pkg::MC_GL] && !r.in_lo);
   endproperty
   a_ret_low: assert property (p_ret_low) else $error("Return did not reopen low.");

   property p_gate_all;
      @(posedge i_ref_clk) disable iff (i_sys_rst)
      !r.mc[pri_pkg::MC_GH] |-> !take;
   endproperty
   a_gate_all: assert property (p_gate_all) else $error("Entry while disabled.");

   property p_periph_gate;
      @(posedge i_ref_clk) disable iff (i_sys_rst)
      (!r.pm && !r.mc[pri_pkg::MC_GL] && act == 5'h00) |-> !take;
   endproperty
   a_periph_gate: assert property (p_periph_gate) else $error("Gated entry.");

   property p_line_flag;
      @(posedge i_ref_clk) disable iff (i_sys_rst)
      ext_ev[1] |=> r.ex[pri_pkg::EX_BF];
   endproperty
   a_line_flag: assert property (p_line_flag) else $error("Line b flag not set.");
endmodule

// ==== bench/pri_core_model.sv ====
// Behavioural core model that takes interrupt entries and issues returns.
`timescale 1ns/1ps
module pri_core_model (
   // Clock and reset.
   input  wire logic          i_ref_clk,
   input  wire logic          i_sys_rst,
   // Entry request and return command.
   input  pri_pkg::pri_entry_t i_entry,
   input  wire logic          i_ret_cmd,
   output logic               o_return_from_irq_instruction,
   output int                 o_depth
);
   logic [20:0] pc_r;
   logic [20:0] stack_r [0:7];

   ////////////////////////////////////////////////////////////////////////
   // Entry pushes the return address and jumps; a return pops it again.
   always @(posedge i_ref_clk) begin
      if (i_sys_rst) begin
         pc_r     <= 21'h000100;
         o_depth  <= 0;
         o_return_from_irq_instruction <= 1'b0;
      end else begin
         o_return_from_irq_instruction <= i_ret_cmd;
         if (i_entry.take === 1'b1 && i_entry.push === 1'b1) begin
            stack_r[o_depth[2:0]] <= pc_r;
            pc_r    <= i_entry.vec;
            o_depth <= o_depth + 1;
         end else if (i_ret_cmd && o_depth > 0) begin
            pc_r    <= stack_r[o_depth[2:0] - 3'h1];
            o_depth <= o_depth - 1;
         end
      end
   end
endmodule

// ==== bench/tb_top.sv ====
// Self-checking testbench for the interrupt controller over APB.
`timescale 1ns/1ps
module tb_top;
   logic                ref_clk = 1'b0;
   logic                sys_rst = 1'b1;
   logic                psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0]          paddr = 8'h00;
   logic [31:0]         pwdata = 32'h0, prdata;
   logic                pready, pslverr, pud;
   logic                tmr0 = 1'b0, port_rd = 1'b0, ret_cmd = 1'b0, return_from_irq_instruction;
   logic [2:0]          ext = 3'h0;
   logic [3:0]          pins = 4'h0;
   logic                per_hi = 1'b0, per_lo = 1'b0;
   pri_pkg::pri_entry_t entry;
   int                  depth, mismatches = 0, n_checks = 0, n;
   logic [31:0]         rd;
   logic                err;

   pri_irq_ctrl pri_irq_ctrl_i (.i_ref_clk(ref_clk), .i_sys_rst(sys_rst), .i_psel(psel),
      .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
      .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .i_tmr0_ovf(tmr0),
      .i_ext_line(ext), .i_upper_port_pins(pins), .i_periph_hi_pend(per_hi),
      .i_periph_lo_pend(per_lo), .i_port_read(port_rd), .i_return_from_irq_instruction(return_from_irq_instruction),
      .o_entry(entry), .o_port_pullup_disable(pud));
   pri_core_model pri_core_model_i (.i_ref_clk(ref_clk), .i_sys_rst(sys_rst),
      .i_entry(entry), .i_ret_cmd(ret_cmd), .o_return_from_irq_instruction(return_from_irq_instruction), .o_depth(depth));

   ////////////////////////////////////////////////////////////////////////
   // Clock at 20 MHz and a watchdog.
   initial begin
      forever #25 ref_clk = ~ref_clk;
   end
   initial begin
      #(50 * 8000);
      mismatches++;
      tally_and_finish();
   end

   ////////////////////////////////////////////////////////////////////////
   // Comparison, APB transfer and core helper tasks.
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   // Each access moves one register, never memory to memory.
   task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      psel    <= 1'b1;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= {24'h0, d};
      @(posedge ref_clk);
      penable <= 1'b1;
      do @(posedge ref_clk); while (pready !== 1'b1);
      rd      = prdata;
      err     = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
      apb(1'b0, a, 8'h00);
      check(rd, {24'h0, exp});
   endtask
   task automatic wait_take();
      n = 0;
      do begin
         @(posedge ref_clk);
         n++;
      end while (entry.take !== 1'b1 && n < 30);
   endtask
   task automatic do_ret();
      @(posedge ref_clk);
      ret_cmd <= 1'b1;
      @(posedge ref_clk);
      ret_cmd <= 1'b0;
      repeat (3) @(posedge ref_clk);
   endtask
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////
   // Test sequence.
   initial begin
      repeat (5) @(posedge ref_clk);
      sys_rst <= 1'b0;
      repeat (2) @(posedge ref_clk);
      // Reset values, masks, pull-up control and an unmapped address.
      rchk(pri_pkg::OFS_MAIN, 8'h00);
      rchk(pri_pkg::OFS_EDGE, 8'hf5);
      rchk(pri_pkg::OFS_EXT, 8'hc0);
      rchk(pri_pkg::OFS_RST, 8'h00);
      check(pud, 1'b1);
      apb(1'b1, pri_pkg::OFS_EDGE, 8'h0a);
      rchk(pri_pkg::OFS_EDGE, 8'h00);
      check(pud, 1'b0);
      apb(1'b1, pri_pkg::OFS_EXT, 8'hff);
      rchk(pri_pkg::OFS_EXT, 8'hdb);
      apb(1'b1, pri_pkg::OFS_EXT, 8'h00);
      rchk(8'h14, 8'h00);
      check(err, 1'b1);
      $display("test registers done");
      // Flags rise with every enable off; falling edges with selects at zero.
      tmr0 <= 1'b1;
      @(posedge ref_clk);
      tmr0 <= 1'b0;
      rchk(pri_pkg::OFS_MAIN, 8'h04);
      rchk(pri_pkg::OFS_MAIN, 8'h04);
      apb(1'b1, pri_pkg::OFS_MAIN, 8'h00);
      ext <= 3'h7;
      repeat (6) @(posedge ref_clk);
      ext <= 3'h0;
      repeat (6) @(posedge ref_clk);
      rchk(pri_pkg::OFS_MAIN, 8'h02);
      rchk(pri_pkg::OFS_EXT, 8'h03);
      pins <= 4'h5;
      repeat (6) @(posedge ref_clk);
      apb(1'b1, pri_pkg::OFS_MAIN, 8'h00);
      rchk(pri_pkg::OFS_MAIN, 8'h01);
      port_rd <= 1'b1;
      @(posedge ref_clk);
      port_rd <= 1'b0;
      apb(1'b1, pri_pkg::OFS_MAIN, 8'h00);
      rchk(pri_pkg::OFS_MAIN, 8'h00);
      apb(1'b1, pri_pkg::OFS_EXT, 8'h00);
      apb(1'b1, pri_pkg::OFS_EDGE, 8'hf5);
      $display("test flags done");
      // Compatibility mode entry from line a, then return.
      apb(1'b1, pri_pkg::OFS_MAIN, 8'h90);
      ext[0] <= 1'b1;
      wait_take();
      // The take pulse is seen one clock after entry, so each bound gains one.
      check(n >= 3 * pri_pkg::CLKS_PER_INSTR + 1, 1'b1);
      check(n <= 4 * pri_pkg::CLKS_PER_INSTR + 1, 1'b1);
      check(entry.vec, pri_pkg::VEC_HIGH);
      rchk(pri_pkg::OFS_MAIN, 8'h12);
      check(depth, 1);
      apb(1'b1, pri_pkg::OFS_MAIN, 8'h10);
      do_ret();
      rchk(pri_pkg::OFS_MAIN, 8'h90);
      // A pending peripheral waits for bit 6, then enters on the single vector.
      per_lo <= 1'b1;
      apb(1'b1, pri_pkg::OFS_MAIN, 8'h80);
      wait_take();
      check(n, 30);
      apb(1'b1, pri_pkg::OFS_MAIN, 8'hc0);
      wait_take();
      check(entry.vec, pri_pkg::VEC_HIGH);
      rchk(pri_pkg::OFS_MAIN, 8'h40);
      per_lo <= 1'b0;
      do_ret();
      rchk(pri_pkg::OFS_MAIN, 8'hc0);
      $display("test compat done");
      // Priority mode: low entry, high preemption, nested returns.
      ext[0] <= 1'b0;
      apb(1'b1, pri_pkg::OFS_RST, 8'h80);
      apb(1'b1, pri_pkg::OFS_EXT, 8'h88);
      apb(1'b1, pri_pkg::OFS_MAIN, 8'h40);
      ext[1] <= 1'b1;
      wait_take();
      check(n, 30);
      rchk(pri_pkg::OFS_EXT, 8'h89);
      apb(1'b1, pri_pkg::OFS_MAIN, 8'hc0);
      wait_take();
      check(entry.vec, pri_pkg::VEC_LOW);
      rchk(pri_pkg::OFS_MAIN, 8'h80);
      apb(1'b1, pri_pkg::OFS_EXT, 8'h88);
      apb(1'b1, pri_pkg::OFS_MAIN, 8'h90);
      ext[0] <= 1'b1;
      wait_take();
      check(entry.vec, pri_pkg::VEC_HIGH);
      rchk(pri_pkg::OFS_MAIN, 8'h12);
      rchk(pri_pkg::OFS_STAT, 8'h03);
      apb(1'b1, pri_pkg::OFS_MAIN, 8'h10);
      do_ret();
      rchk(pri_pkg::OFS_MAIN, 8'h90);
      do_ret();
      rchk(pri_pkg::OFS_MAIN, 8'hd0);
      check(depth, 0);
      $display("test priority done");
      tally_and_finish();
   end
endmodule
